// ===== verilog/nvp_ctl.sv
/*
 Command logic of an embedded nonvolatile page memory: erase, normal and
 read-ahead reads, page information reads, write, program, unprotect and
 discard, with an APB slave for threshold, fault injection and test flags.
 Assumes user logic on pclk that presents commands only while busy is low.
*/
`default_nettype none
`include "nvp_regs.svh"
module nvp_ctl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        read_strobe,
    input  wire logic        write_strobe,
    input  wire logic        page_erase_req,
    input  wire logic        program_req,
    input  wire logic        clear_guard_req,
    input  wire logic        drop_buffer_req,
    input  wire logic        sequential_prefetch,
    input  wire logic        page_info_select,
    input  wire logic [1:0]  read_target,
    input  wire logic        output_stage_select,
    input  wire logic        alt_destination_select,
    input  wire logic        buffer_keep_guard,
    input  wire logic        guard_on_program,
    input  wire logic [7:0]  nv_addr,
    input  wire logic [31:0] wr_data,
    output logic             busy,
    output logic [1:0]       result,
    output logic [31:0]      rd_data,
    output logic             rd_valid
);
    localparam nvp_pkg::nvp_state_t RST_S = '{st: nvp_pkg::NVP_IDLE, op: nvp_pkg::NVP_RD,
                                              thr: `NVP_THR_RST, default: '0};

    nvp_pkg::nvp_state_t s_r;
    nvp_pkg::nvp_state_t s_nxt;
    logic                acc;
    logic                fin;
    logic [3:0]          pg;
    logic [3:0]          tpg;
    logic [1:0]          ec;
    logic [3:0]          pipe;
    logic [31:0]         word;
    logic [31:0]         apb_val;
    logic [31:0]         stat_w;
    logic                foreign;

    function automatic logic apb_hit(input logic [11:0] a);
        return a == `NVP_R_THR || a == `NVP_R_ECC ||
               a == `NVP_R_PROT || a == `NVP_R_STAT;
    endfunction : apb_hit

    // Fault injection: {double, single} for accesses to the chosen page
    function automatic logic [1:0] ecc_of(input logic [7:0] e, input logic [3:0] p);
        return (e[`NVP_E_PG] == p) ? {e[`NVP_E_DBL], e[`NVP_E_SGL]} : 2'b00;
    endfunction : ecc_of

    function automatic logic [1:0] ecc_res(input logic [1:0] e);
        return e[1] ? `NVP_RES_UNC : (e[0] ? `NVP_RES_FIX : `NVP_RES_OK);
    endfunction : ecc_res

    function automatic logic [7:0] next_addr(input logic [7:0] a);
        logic [7:0] n;
        n = a;
        if (a[`NVP_A_AUX])
        begin
            n[`NVP_A_PG] = a[`NVP_A_PG] + 4'h1;
        end
        else if (a[`NVP_A_SPR])
        begin
            n[`NVP_A_SEC] = a[`NVP_A_SEC] + 2'h1;
            n[`NVP_A_PIS] = 2'h0;
            n[`NVP_A_BLK] = 2'h0;
        end
        else if (a[`NVP_A_BLK] == `NVP_BLK_LAST)
        begin
            n[`NVP_A_PG] = a[`NVP_A_PG] + 4'h1;
            n[`NVP_A_BLK] = 2'h0;
        end
        else
        begin
            n[`NVP_A_BLK] = a[`NVP_A_BLK] + 2'h1;
        end
        return n;
    endfunction : next_addr

    // Spare and auxiliary blocks hold no modelled content and read as zero
    function automatic logic [31:0] arr_word(input nvp_pkg::nvp_state_t s,
                                             input logic [7:0] a);
        return (a[`NVP_A_AUX] || a[`NVP_A_SPR]) ? '0 : s.mem[a[5:0]];
    endfunction : arr_word

    function automatic logic [31:0] info_word(input nvp_pkg::nvp_state_t s,
                                              input logic [3:0] p);
        return {s.wcnt[p], `NVP_INFO_RSV, s.wcnt[p] > s.thr,
                s.tprot[p], s.tprot[16 + p], s.guard[p]};
    endfunction : info_word

    assign pg      = s_r.cmd.addr[`NVP_A_PG];
    assign ec      = ecc_of(s_r.ecc, pg);
    assign tpg     = s_r.cmd.alt ? pg : s_r.buf_page;
    assign foreign = !s_r.buf_valid || pg != s_r.buf_page;
    assign word    = arr_word(s_r, s_r.cmd.addr);
    assign pipe    = {3'h0, output_stage_select};
    assign fin     = s_r.st == nvp_pkg::NVP_RUN && s_r.cnt == 4'h0;
    // Status word shared by the bus and by status-target reads, independent of paddr
    assign stat_w  = {20'h0, s_r.buf_page, s_r.buf_mod, s_r.buf_valid,
                      s_r.pf_valid, s_r.result, 2'h0, busy};

    always_comb
    begin
        case (paddr)
            `NVP_R_THR:  apb_val = {8'h00, s_r.thr};
            `NVP_R_ECC:  apb_val = {24'h0, s_r.ecc};
            `NVP_R_PROT: apb_val = s_r.tprot;
            `NVP_R_STAT: apb_val = stat_w;
            default:     apb_val = '0;
        endcase
    end

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rd_valid = 1'b0;
        acc = 1'b0;
        // Read data is latched in the setup cycle so the zero-wait access phase sees flops
        if (psel && !penable)
        begin
            s_nxt.prdata = apb_val;
            s_nxt.pslverr = !apb_hit(paddr);
        end
        if (psel && penable && pwrite)
        begin
            case (paddr)
                `NVP_R_THR:  s_nxt.thr = pwdata[23:0];
                `NVP_R_ECC:  s_nxt.ecc = pwdata[7:0];
                `NVP_R_PROT: s_nxt.tprot = pwdata;
                default:     s_nxt.thr = s_r.thr;
            endcase
        end
        // Background array fetch for read-ahead
        if (s_r.pf_cnt != 4'h0)
        begin
            s_nxt.pf_cnt = s_r.pf_cnt - 4'h1;
            if (s_r.pf_cnt == 4'h1)
            begin
                s_nxt.pf_valid = 1'b1;
                s_nxt.pf_data = arr_word(s_r, s_r.pf_addr);
                s_nxt.pf_err = ecc_of(s_r.ecc, s_r.pf_addr[`NVP_A_PG]);
            end
        end
        case (s_r.st)
            nvp_pkg::NVP_IDLE:
            begin
                acc = read_strobe || write_strobe || page_erase_req ||
                      program_req || clear_guard_req || drop_buffer_req;
                s_nxt.cmd = '{addr: nv_addr, wdata: wr_data, seq: sequential_prefetch,
                              info: page_info_select, tgt: read_target,
                              alt: alt_destination_select, keep: buffer_keep_guard,
                              gop: guard_on_program, hit: 1'b0};
                s_nxt.st = acc ? nvp_pkg::NVP_RUN : nvp_pkg::NVP_IDLE;
                s_nxt.cnt = `NVP_WR_CYC;
                // Simultaneous requests resolve read, write, erase, program, unprotect, discard
                if (read_strobe)
                begin
                    s_nxt.op = nvp_pkg::NVP_RD;
                    s_nxt.cnt = pipe;
                    if (!page_info_select && read_target == 2'b00)
                    begin
                        s_nxt.cnt = `NVP_RD_CYC + pipe;
                        if (sequential_prefetch && s_r.pf_valid && nv_addr == s_r.pf_addr)
                        begin
                            s_nxt.cmd.hit = 1'b1;
                            s_nxt.cnt = pipe;
                        end
                        else if (sequential_prefetch && s_r.pf_cnt != 4'h0)
                        begin
                            s_nxt.st = nvp_pkg::NVP_WAIT;
                        end
                    end
                end
                else if (write_strobe)
                    s_nxt.op = nvp_pkg::NVP_WR;
                else if (page_erase_req)
                begin
                    s_nxt.op = nvp_pkg::NVP_ER;
                    s_nxt.cnt = `NVP_ER_CYC;
                end
                else if (program_req)
                begin
                    s_nxt.op = nvp_pkg::NVP_PG;
                    s_nxt.cnt = `NVP_ER_CYC;
                end
                else if (clear_guard_req)
                    s_nxt.op = nvp_pkg::NVP_UP;
                else if (drop_buffer_req)
                begin
                    s_nxt.op = nvp_pkg::NVP_DS;
                    s_nxt.cnt = `NVP_DS_CYC;
                end
            end
            nvp_pkg::NVP_WAIT:
            begin
                // The running prefetch cannot be cancelled; it must drain first
                if (s_r.pf_cnt == 4'h0)
                begin
                    s_nxt.st = nvp_pkg::NVP_RUN;
                    s_nxt.cnt = `NVP_RD_CYC + pipe;
                end
            end
            nvp_pkg::NVP_RUN:
            begin
                if (s_r.cnt != 4'h0)
                    s_nxt.cnt = s_r.cnt - 4'h1;
                else
                begin
                    s_nxt.st = nvp_pkg::NVP_IDLE;
                    s_nxt.result = `NVP_RES_OK;
                    case (s_r.op)
                        nvp_pkg::NVP_RD:
                        begin
                            s_nxt.rd_valid = 1'b1;
                            s_nxt.rd_info = s_r.cmd.info;
                            if (s_r.cmd.info)
                                s_nxt.rd_data = info_word(s_r, pg);
                            else if (s_r.cmd.tgt == 2'b01)
                                s_nxt.rd_data = s_r.pbuf[s_r.cmd.addr[`NVP_A_BLK]];
                            else if (s_r.cmd.tgt == 2'b10)
                                s_nxt.rd_data = s_r.blk;
                            else if (s_r.cmd.tgt == 2'b11)
                                s_nxt.rd_data = stat_w;
                            else
                            begin
                                s_nxt.rd_data = s_r.cmd.hit ? s_r.pf_data : word;
                                s_nxt.result = ecc_res(s_r.cmd.hit ? s_r.pf_err : ec);
                                if (s_nxt.result == `NVP_RES_UNC)
                                    s_nxt.rd_data = s_nxt.rd_data ^ `NVP_DBL_FLIP;
                                s_nxt.blk = s_nxt.rd_data;
                                if (s_r.cmd.seq)
                                begin
                                    s_nxt.pf_addr = next_addr(s_r.cmd.addr);
                                    s_nxt.pf_cnt = `NVP_RD_CYC;
                                    s_nxt.pf_valid = 1'b0;
                                end
                            end
                        end
                        nvp_pkg::NVP_WR:
                        begin
                            if (s_r.guard[pg])
                                s_nxt.result = `NVP_RES_REF;
                            else if (foreign && s_r.cmd.keep && s_r.buf_mod)
                                s_nxt.result = `NVP_RES_LIM;
                            else
                            begin
                                if (foreign)
                                    for (int i = 0; i < 4; i++)
                                        s_nxt.pbuf[i] = s_r.mem[{pg, i[1:0]}];
                                s_nxt.pbuf[s_r.cmd.addr[`NVP_A_BLK]] = s_r.cmd.wdata;
                                s_nxt.buf_page = pg;
                                s_nxt.buf_valid = 1'b1;
                                s_nxt.buf_mod = 1'b1;
                            end
                        end
                        nvp_pkg::NVP_ER:
                        begin
                            if (s_r.guard[pg] ||
                                (foreign && s_r.buf_mod && s_r.cmd.keep) ||
                                (foreign && s_r.buf_mod && !s_r.cmd.alt))
                                s_nxt.result = `NVP_RES_REF;
                            else
                            begin
                                for (int i = 0; i < 4; i++)
                                    s_nxt.mem[{pg, i[1:0]}] = '0;
                                s_nxt.wcnt[pg] = s_r.wcnt[pg] + 24'h1;
                                if (s_nxt.wcnt[pg] > s_r.thr)
                                    s_nxt.result = `NVP_RES_LIM;
                                else if (ec[`NVP_E_DBL])
                                    s_nxt.result = `NVP_RES_UNC;
                            end
                        end
                        nvp_pkg::NVP_PG:
                        begin
                            if (s_r.guard[tpg] || !s_r.buf_valid)
                                s_nxt.result = `NVP_RES_REF;
                            else
                            begin
                                for (int i = 0; i < 4; i++)
                                    s_nxt.mem[{tpg, i[1:0]}] = s_r.pbuf[i];
                                s_nxt.guard[tpg] = s_r.cmd.gop;
                                s_nxt.wcnt[tpg] = s_r.wcnt[tpg] + 24'h1;
                                s_nxt.buf_mod = 1'b0;
                                if (s_nxt.wcnt[tpg] > s_r.thr)
                                    s_nxt.result = `NVP_RES_LIM;
                            end
                        end
                        nvp_pkg::NVP_UP:
                        begin
                            if (foreign && s_r.cmd.keep && s_r.buf_mod)
                                s_nxt.result = `NVP_RES_LIM;
                            else
                            begin
                                s_nxt.guard[pg] = 1'b0;
                                if (foreign)
                                begin
                                    for (int i = 0; i < 4; i++)
                                        s_nxt.pbuf[i] = s_r.mem[{pg, i[1:0]}];
                                    if (ec[`NVP_E_DBL])
                                        s_nxt.pbuf[0] = s_r.mem[{pg, 2'h0}] ^ `NVP_DBL_FLIP;
                                    s_nxt.buf_page = pg;
                                    s_nxt.buf_valid = 1'b1;
                                    s_nxt.buf_mod = 1'b0;
                                    s_nxt.result = ecc_res(ec);
                                end
                            end
                        end
                        nvp_pkg::NVP_DS:
                            s_nxt.buf_mod = 1'b0;
                        default:
                            s_nxt.result = `NVP_RES_OK;
                    endcase
                end
            end
            default:
                s_nxt.st = nvp_pkg::NVP_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_r <= RST_S;
        else
            s_r <= s_nxt;
    end

    assign busy     = s_r.st != nvp_pkg::NVP_IDLE;
    assign result   = s_r.result;
    assign rd_data  = s_r.rd_data;
    assign rd_valid = s_r.rd_valid;
    assign prdata   = s_r.prdata;
    assign pslverr  = s_r.pslverr;
    assign pready   = 1'b1;

    accept_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc |=> busy)
        else $error("accepted command did not raise busy");

    result_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !busy && $past(!busy) |-> $stable(result))
        else $error("result changed while idle");

    miss_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        acc && read_strobe && sequential_prefetch |-> ##[1:10] rd_valid)
        else $error("read-ahead data later than nine busy cycles");

    info_rsv_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_valid && s_r.rd_info |-> rd_data[7:4] == `NVP_INFO_RSV)
        else $error("info word reserved bits not zero");

    guard_erase_a: assert property (@(posedge pclk) disable iff (!presetn)
        fin && s_r.op == nvp_pkg::NVP_ER && s_r.guard[pg]
        |=> result == `NVP_RES_REF && $stable(s_r.mem))
        else $error("guarded page erased");

    erase_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        fin && s_r.op == nvp_pkg::NVP_ER
        |=> result == `NVP_RES_REF || s_r.mem[{$past(pg), `NVP_BLK_LAST}] == '0)
        else $error("erased page not cleared");

    drop_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        fin && s_r.op == nvp_pkg::NVP_DS |=> !s_r.buf_mod && !busy)
        else $error("discard left buffer modified");

    dbl_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        fin && s_r.op == nvp_pkg::NVP_RD && !s_r.cmd.hit && !s_r.cmd.info &&
        s_r.cmd.tgt == 2'b00 && ec[`NVP_E_DBL] |=> result == `NVP_RES_UNC && rd_valid)
        else $error("double-bit read not reported");

    up_loss_a: assert property (@(posedge pclk) disable iff (!presetn)
        fin && s_r.op == nvp_pkg::NVP_UP && foreign && s_r.cmd.keep && s_r.buf_mod
        |=> result == `NVP_RES_LIM && $stable(s_r.pbuf))
        else $error("unprotect overwrote loss-protected buffer");
endmodule : nvp_ctl
`default_nettype wire

// ===== pkg/nvp_regs.svh
/*
 Constants of the page memory command block: register offsets, result codes,
 address fields and cycle counts. Included by the package and the design.
*/
`ifndef NVP_REGS_SVH
`define NVP_REGS_SVH
`define NVP_R_THR     12'h000
`define NVP_R_ECC     12'h004
`define NVP_R_PROT    12'h008
`define NVP_R_STAT    12'h00c
`define NVP_THR_RST   24'h000100
`define NVP_RD_CYC    4'h3
`define NVP_WR_CYC    4'h4
`define NVP_ER_CYC    4'h6
`define NVP_DS_CYC    4'h2
`define NVP_RES_OK    2'b00
`define NVP_RES_REF   2'b01
`define NVP_RES_FIX   `NVP_RES_REF
`define NVP_RES_UNC   2'b10
`define NVP_RES_LIM   2'b11
`define NVP_A_AUX     7
`define NVP_A_SPR     6
`define NVP_A_SEC     5:4
`define NVP_A_PIS     3:2
`define NVP_A_PG      5:2
`define NVP_A_BLK     1:0
`define NVP_BLK_LAST  2'h3
`define NVP_E_SGL     0
`define NVP_E_DBL     1
`define NVP_E_PG      7:4
`define NVP_INFO_RSV  4'h0
`define NVP_DBL_FLIP  32'h0000_0001
`endif

// ===== pkg/nvp_pkg.sv
/*
 Types of the page memory command block: states, operations, the captured
 command and the whole state record. Assumes nvp_regs.svh on the include path.
*/
`default_nettype none
`include "nvp_regs.svh"
package nvp_pkg;
    typedef enum logic [1:0] {
        NVP_IDLE = 2'b00,
        NVP_WAIT = 2'b01,
        NVP_RUN  = 2'b10
    } nvp_st_t;

    typedef enum logic [2:0] {
        NVP_RD = 3'b000,
        NVP_WR = 3'b001,
        NVP_ER = 3'b010,
        NVP_PG = 3'b011,
        NVP_UP = 3'b100,
        NVP_DS = 3'b101
    } nvp_op_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        seq;
        logic        info;
        logic [1:0]  tgt;
        logic        alt;
        logic        keep;
        logic        gop;
        logic        hit;
    } nvp_cmd_t;

    typedef struct packed {
        nvp_st_t           st;
        nvp_op_t           op;
        logic [3:0]        cnt;
        nvp_cmd_t          cmd;
        logic [1:0]        result;
        logic [31:0]       rd_data;
        logic              rd_valid;
        logic              rd_info;
        logic [3:0]        buf_page;
        logic              buf_valid;
        logic              buf_mod;
        logic [3:0][31:0]  pbuf;
        logic [31:0]       blk;
        logic [7:0]        pf_addr;
        logic [3:0]        pf_cnt;
        logic              pf_valid;
        logic [31:0]       pf_data;
        logic [1:0]        pf_err;
        logic [63:0][31:0] mem;
        logic [15:0][23:0] wcnt;
        logic [15:0]       guard;
        logic [23:0]       thr;
        logic [7:0]        ecc;
        logic [31:0]       tprot;
        logic [31:0]       prdata;
        logic              pslverr;
    } nvp_state_t;
endpackage : nvp_pkg
`default_nettype wire

// ===== verif/nvp_user.sv
/* User-side command driver for the page memory block.
   Assumes busy from the design, sampled on pclk. */
`default_nettype none
module nvp_user (
    input  wire logic        pclk,
    input  wire logic        busy,
    output var logic [5:0]   req,
    output var nvp_pkg::nvp_cmd_t c
);
    timeunit 1ns;
    timeprecision 1ps;
    int n;
    initial
    begin
        req = '0;
        c = '0;
    end
    // One-cycle request; n counts busy cycles up to completion
    task automatic go(input int k, input nvp_pkg::nvp_cmd_t v);
        @(posedge pclk);
        req <= 6'h1 << k;
        c <= v;
        @(posedge pclk);
        req <= 6'h0;
        // Qualifiers are stale once taken, so they are scrambled
        c <= nvp_pkg::nvp_cmd_t'(~v);
        n = -1;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (busy === 1'h1 && n < 40);
    endtask : go
endmodule : nvp_user
`default_nettype wire

// ===== verif/tb.sv
/* Self-checking bench for the page memory command block.
   Assumes nvp_user on the command side and a zero-wait APB slave. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stg = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd_data;
    logic [31:0] w [4] = '{default: 32'h0};
    logic        pready, pslverr, busy, rd_valid;
    logic [1:0]  result;
    logic [5:0]  req;
    logic [1:0]  tgt = '0;
    logic [7:0]  pa [5] = '{8'h04, 8'h0f, 8'h3f, 8'h70, 8'h80};
    logic [7:0]  pb [5] = '{8'h05, 8'h10, 8'h00, 8'h40, 8'h84};
    nvp_pkg::nvp_cmd_t c;
    int seed = 79684, mismatches = 0, check_count = 0;
    nvp_user nvp_user_inst (.pclk(pclk), .busy(busy), .req(req), .c(c));
    nvp_ctl nvp_ctl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .read_strobe(req[0]), .write_strobe(req[1]),
        .page_erase_req(req[2]), .program_req(req[3]), .clear_guard_req(req[4]),
        .drop_buffer_req(req[5]), .sequential_prefetch(c.seq), .page_info_select(c.info),
        .read_target(c.tgt), .output_stage_select(stg), .alt_destination_select(c.alt),
        .buffer_keep_guard(c.keep), .guard_on_program(c.gop), .nv_addr(c.addr),
        .wr_data(c.wdata), .busy(busy), .result(result), .rd_data(rd_data),
        .rd_valid(rd_valid));
    initial forever #5 pclk = ~pclk;
    task automatic chk(input logic [33:0] s, input logic [33:0] x);
        check_count++;
        if (s !== x)
        begin
            mismatches++;
            $display("wrong value at %0t seen %h expected %h", $time, s, x);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] x);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        if (!wr) chk({pslverr, prdata}, x);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic op(input int k, input logic [7:0] a, input logic [4:0] f,
                      input logic [1:0] r);
        nvp_pkg::nvp_cmd_t v;
        v = '0;
        v.addr = a;
        v.wdata = w[a[1:0]];
        v.tgt = tgt;
        {v.seq, v.info, v.gop, v.alt, v.keep} = f;
        nvp_user_inst.go(k, v);
        chk(result, r);
    endtask : op
    initial
    begin
        repeat (6000) @(posedge pclk);
        mismatches++;
        summarize();
    end
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        chk({busy, result}, 3'h0);
        apb(1'h0, 12'h000, 32'h0, {1'h0, 32'h100});
        apb(1'h0, 12'h010, 32'h0, {1'h1, 32'h0});
        op(0, 8'($random(seed)) & 8'h3f, 5'h0, 2'h0);
        chk({rd_valid, rd_data}, 33'h100000000);
        for (int i = 0; i < 4; i++)
        begin
            w[i] = $random(seed);
            op(1, 8'h04 + 8'(i), 5'h0, 2'h0);
        end
        op(3, 8'h04, 5'h04, 2'h0);
        op(0, 8'h04, 5'h08, 2'h0);
        chk(rd_data, 32'h101);
        op(2, 8'h04, 5'h0, 2'h1);
        repeat (3) @(posedge pclk);
        chk(result, 2'h1);
        op(0, 8'h06, 5'h0, 2'h0);
        chk(rd_data, w[2]);
        op(4, 8'h04, 5'h0, 2'h0);
        op(2, 8'h04, 5'h0, 2'h0);
        op(0, 8'h07, 5'h0, 2'h0);
        chk(rd_data, 32'h0);
        op(0, 8'h04, 5'h08, 2'h0);
        chk(rd_data, 32'h200);
        apb(1'h1, 12'h000, 32'h0, '0);
        op(2, 8'h04, 5'h0, 2'h3);
        apb(1'h1, 12'h000, 32'h100, '0);
        apb(1'h1, 12'h004, 32'h11, '0);
        op(0, 8'h06, 5'h0, 2'h1);
        apb(1'h1, 12'h004, 32'h12, '0);
        op(0, 8'h06, 5'h0, 2'h2);
        chk(rd_data, 32'h1);
        op(2, 8'h04, 5'h0, 2'h2);
        apb(1'h1, 12'h004, 32'h0, '0);
        for (int i = 0; i < 5; i++)
        begin
            op(0, pa[i], 5'h10, 2'h0);
            repeat (5) @(posedge pclk);
            op(0, pb[i], 5'h10, 2'h0);
            chk(nvp_user_inst.n, 1);
        end
        op(0, 8'h08, 5'h10, 2'h0);
        op(0, 8'h30, 5'h10, 2'h0);
        chk(nvp_user_inst.n <= 9, 1);
        repeat (5) @(posedge pclk);
        stg <= 1'h1;
        op(0, 8'h09, 5'h0, 2'h0);
        chk(nvp_user_inst.n, 5);
        @(posedge pclk);
        stg <= 1'h0;
        tgt = 2'h1;
        op(0, 8'h05, 5'h0, 2'h0);
        chk(rd_data, w[1]);
        tgt = 2'h3;
        op(0, 8'h05, 5'h0, 2'h0);
        chk(rd_data, 32'h161);
        tgt = 2'h0;
        op(1, 8'h04, 5'h0, 2'h0);
        op(4, 8'h08, 5'h01, 2'h3);
        op(5, 8'h04, 5'h0, 2'h0);
        chk(nvp_user_inst.n, 3);
        apb(1'h1, 12'h004, 32'h21, '0);
        op(4, 8'h08, 5'h0, 2'h1);
        apb(1'h1, 12'h004, 32'h32, '0);
        op(4, 8'h0c, 5'h0, 2'h2);
        tgt = 2'h1;
        op(0, 8'h0c, 5'h0, 2'h0);
        chk(rd_data, 32'h1);
        summarize();
    end
endmodule : tb
`default_nettype wire
